// *** core/ierb_pack.sv ***
// Packs the fields of one event into a 32-byte record, zeroing every undefined part.
`timescale 1ns/1ps
module ierb_pack #(
    parameter int OAS_BITS = 48,
    parameter bit REV0 = 1'b1
) (
    // Event fields.
    input wire logic [7:0] code,
    input wire logic substream_valid,
    input wire logic [19:0] ssid,
    input wire logic [31:0] sid,
    input wire logic [15:0] reason,
    input wire logic read_not_write,
    input wire logic priv,
    input wire logic instr,
    input wire logic stage,
    input wire logic [1:0] op_class,
    input wire logic nonsecure_ipa_flag,
    input wire logic [63:0] in_addr,
    input wire logic [63:0] fetch_addr,
    // Packed record.
    output logic [ierb_pkg::RECORD_BITS-1:0] record
);
    logic [63:0] fa;
    logic is_uut;
    logic is_fetch;

    // Address bits above the output size are dropped to zero rather than left unknown.
    always_comb begin
        fa = fetch_addr;
        for (int i = 0; i < 64; i++) begin
            if (i >= OAS_BITS) begin
                fa[i] = 1'b0;
            end
        end
        if (REV0) begin
            fa[51:48] = 4'h0;
        end
    end

    assign is_uut = (code == ierb_pkg::CODE_UUT);
    assign is_fetch = (code == ierb_pkg::CODE_FETCH);

    // Start from zero so any bit without a field stays clear.
    always_comb begin
        record = '0;
        record[ierb_pkg::POS_CODE +: 8] = code;
        record[ierb_pkg::POS_SID +: 32] = sid;
        record[ierb_pkg::POS_SSV] = substream_valid;
        if (substream_valid) begin
            record[ierb_pkg::POS_SSID +: ierb_pkg::SSID_W] = ssid;
        end
        if (is_uut || is_fetch) begin
            record[ierb_pkg::POS_REASON +: ierb_pkg::REASON_W] = reason;
        end
        if (is_uut) begin
            record[ierb_pkg::POS_RNW] = read_not_write;
            record[ierb_pkg::POS_PRIV] = priv;
            record[ierb_pkg::POS_INSTR] = instr;
            record[ierb_pkg::POS_STAGE] = stage;
            record[ierb_pkg::POS_CLASS +: 2] = (op_class == 2'h3) ? 2'h0 : op_class;
            record[ierb_pkg::POS_NONSECURE_IPA_FLAG] = nonsecure_ipa_flag;
            record[ierb_pkg::POS_IN_ADDR +: 64] = in_addr;
        end
        if (is_fetch) begin
            record[ierb_pkg::POS_FETCH +: 64] = fa;
        end
    end
endmodule

// *** core/ierb_pkg.sv ***
// Shared constants for the event record builder: timing, codes, layout and registers.
package ierb_pkg;
    // Clock rate and the merge window, a longest time that rounds down.
    localparam int CLK_MHZ = 40;
    localparam int MERGE_WINDOW_NS = 1600;
    localparam int MERGE_WINDOW_CYC = (MERGE_WINDOW_NS * CLK_MHZ) / 1000;

    // Record size.
    localparam int RECORD_BYTES = 32;
    localparam int RECORD_BITS = RECORD_BYTES * 8;

    // Event codes; zero means no record.
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_UUT = 8'h01;
    localparam logic [7:0] CODE_BAD_SID = 8'h02;
    localparam logic [7:0] CODE_FETCH = 8'h03;
    localparam logic [7:0] CODE_BAD_ENTRY = 8'h04;

    // Operation classes.
    localparam logic [1:0] CLASS_CD = 2'h0;
    localparam logic [1:0] CLASS_TTD = 2'h1;
    localparam logic [1:0] CLASS_IN = 2'h2;

    // Field positions inside the 256-bit record.
    localparam int POS_CODE = 0;
    localparam int POS_SSV = 11;
    localparam int POS_SSID = 12;
    localparam int SSID_W = 20;
    localparam int POS_SID = 32;
    localparam int POS_REASON = 64;
    localparam int REASON_W = 16;
    localparam int POS_RNW = 96;
    localparam int POS_INSTR = 97;
    localparam int POS_PRIV = 98;
    localparam int POS_NONSECURE_IPA_FLAG = 100;
    localparam int POS_STAGE = 103;
    localparam int POS_CLASS = 104;
    localparam int POS_IN_ADDR = 128;
    localparam int POS_FETCH = 192;

    // Register offsets.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_TABLE = 12'h004;
    localparam logic [11:0] OFF_COUNT = 12'h008;
    localparam logic [11:0] OFF_LAST = 12'h00c;

    // Control bits, table fields and reset values.
    localparam int CTRL_TRANS_EN = 0;
    localparam int CTRL_RECINV = 1;
    localparam int CTRL_MERGE = 2;
    localparam int CTRL_TWO_LEVEL = 3;
    localparam int TABLE_LOG2_LSB = 0;
    localparam int TABLE_SPLIT_LSB = 8;
    localparam logic [3:0] CTRL_RESET = 4'h4;
    localparam logic [5:0] LOG2_RESET = 6'h00;
    localparam logic [5:0] SPLIT_RESET = 6'h00;
endpackage

// *** core/ierb_top.sv ***
// Event record builder: classifies pre-entry events, packs, merges and hands records out.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ierb_top #(
    parameter int OAS_BITS = 48,
    parameter bit REV0 = 1'b1,
    parameter int SPAN_RESERVED = 12,
    parameter int MERGE_CYC = ierb_pkg::MERGE_WINDOW_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event request from the translation front end.
    input wire logic evt_valid,
    output logic evt_ready,
    input wire logic evt_unsupported,
    input wire logic [15:0] evt_reason,
    input wire logic evt_secure,
    input wire logic [31:0] evt_source_identifier,
    input wire logic evt_substream_valid,
    input wire logic [19:0] evt_sub_stream_identifier,
    input wire logic evt_read_not_write,
    input wire logic evt_priv_in,
    input wire logic evt_instr_in,
    input wire logic evt_priv_ovr,
    input wire logic evt_instr_ovr,
    input wire logic [63:0] evt_input_address,
    input wire logic evt_fault_stage,
    input wire logic [1:0] evt_op_class,
    input wire logic evt_stage1_ns,
    input wire logic evt_stall,
    input wire logic evt_level1_fetched,
    input wire logic [4:0] evt_level1_span,
    input wire logic evt_fetch_abort,
    input wire logic [63:0] evt_fetch_address,
    input wire logic evt_entry_invalid,
    input wire logic evt_merge_events_enable,
    // Record toward the event queue writer.
    output logic rec_valid,
    input wire logic rec_ready,
    output logic rec_secure,
    output logic [ierb_pkg::RECORD_BITS-1:0] rec_data
);
    initial begin
        if (OAS_BITS < 32 || OAS_BITS > 64 || MERGE_CYC < 1 || MERGE_CYC > 65535) begin
            $error("ierb_top: parameter out of range");
        end
    end

    logic [3:0] ctrl;
    logic [5:0] table_size_log2;
    logic [5:0] split;
    logic [15:0] issued_count;
    logic [15:0] merged_count;
    logic [15:0] window;
    logic apb_access;
    logic apb_commit;
    logic [31:0] rd_word;
    logic rd_ok;
    logic accept;
    logic [7:0] next_code;
    logic [32:0] sid_ext;
    logic [32:0] low_bits;
    logic sid_over;
    logic span_bad;
    logic low_over;
    logic l1_bad;
    logic sel_priv;
    logic sel_instr;
    logic nonsecure_ipa_flag;
    logic [ierb_pkg::RECORD_BITS-1:0] packed_rec;
    logic same_rec;
    logic merge_ok;
    logic merge_hit;
    logic issue;

    // APB access phase; the answer comes one cycle after penable rises.
    assign apb_access = psel && penable && !pready;
    assign apb_commit = psel && penable && pready;

    // Read decode; an unmapped offset answers zero with an error.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (paddr)
            ierb_pkg::OFF_CTRL: rd_word[3:0] = ctrl;
            ierb_pkg::OFF_TABLE: begin
                rd_word[ierb_pkg::TABLE_LOG2_LSB +: 6] = table_size_log2;
                rd_word[ierb_pkg::TABLE_SPLIT_LSB +: 6] = split;
            end
            ierb_pkg::OFF_COUNT: rd_word = {merged_count, issued_count};
            ierb_pkg::OFF_LAST: rd_word = {23'h000000, rec_secure, rec_data[7:0]};
            default: rd_ok = 1'b0;
        endcase
    end

    // Bus answer registers, so every bus output comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && !rd_ok;
            prdata <= (apb_access && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration writes land only at the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ierb_pkg::CTRL_RESET;
            table_size_log2 <= ierb_pkg::LOG2_RESET;
            split <= ierb_pkg::SPLIT_RESET;
        end else if (apb_commit && pwrite) begin
            if (paddr == ierb_pkg::OFF_CTRL) begin
                ctrl <= pwdata[3:0];
            end
            if (paddr == ierb_pkg::OFF_TABLE) begin
                table_size_log2 <= pwdata[ierb_pkg::TABLE_LOG2_LSB +: 6];
                split <= pwdata[ierb_pkg::TABLE_SPLIT_LSB +: 6];
            end
        end
    end

    // Stream identifier range checks; 33 bits keep a full 32-bit table size legal.
    always_comb begin
        sid_ext = {1'b0, evt_source_identifier};
        sid_over = sid_ext >= (33'h1 << table_size_log2);
        low_bits = sid_ext & ((33'h1 << split) - 33'h1);
        span_bad = (evt_level1_span == 5'h00)
            || ({27'h0, evt_level1_span} >= SPAN_RESERVED)
            || ({2'h0, evt_level1_span} > ({1'b0, split} + 7'h01));
        low_over = (evt_level1_span != 5'h00)
            && (low_bits >= (33'h1 << (evt_level1_span - 5'h01)));
        l1_bad = ctrl[ierb_pkg::CTRL_TWO_LEVEL] && evt_level1_fetched
            && (span_bad || low_over);
    end

    // Event selection in priority order; an unsupported type wins even when disabled.
    always_comb begin
        next_code = ierb_pkg::CODE_NONE;
        if (evt_unsupported) begin
            next_code = ierb_pkg::CODE_UUT;
        end else if (!ctrl[ierb_pkg::CTRL_TRANS_EN]) begin
            next_code = ierb_pkg::CODE_NONE;
        end else if (sid_over || l1_bad) begin
            if (ctrl[ierb_pkg::CTRL_RECINV]) begin
                next_code = ierb_pkg::CODE_BAD_SID;
            end
        end else if (evt_fetch_abort) begin
            next_code = ierb_pkg::CODE_FETCH;
        end else if (evt_entry_invalid) begin
            next_code = ierb_pkg::CODE_BAD_ENTRY;
        end
    end

    // Attribute selection and the secure-only stage-two IPA flag.
    assign sel_priv = (next_code == ierb_pkg::CODE_UUT) ? evt_priv_in : evt_priv_ovr;
    assign sel_instr = (next_code == ierb_pkg::CODE_UUT) ? evt_instr_in : evt_instr_ovr;
    assign nonsecure_ipa_flag = evt_secure && evt_fault_stage && evt_stage1_ns;

    ierb_pack #(
        .OAS_BITS(OAS_BITS),
        .REV0(REV0)
    ) u_pack (
        .code(next_code),
        .substream_valid(evt_substream_valid),
        .ssid(evt_sub_stream_identifier),
        .sid(evt_source_identifier),
        .reason(evt_reason),
        .read_not_write(evt_read_not_write),
        .priv(sel_priv),
        .instr(sel_instr),
        .stage(evt_fault_stage),
        .op_class(evt_op_class),
        .nonsecure_ipa_flag(nonsecure_ipa_flag),
        .in_addr(evt_input_address),
        .fetch_addr(evt_fetch_address),
        .record(packed_rec)
    );

    // Merge decision; the whole packed record is compared, so every field must match.
    // The four pre-entry codes ignore the stream's merge enable, as no entry exists yet.
    assign accept = evt_valid && evt_ready;
    assign same_rec = (packed_rec == rec_data) && (evt_secure == rec_secure);
    assign merge_ok = ctrl[ierb_pkg::CTRL_MERGE] && !evt_stall
        && ((next_code <= ierb_pkg::CODE_BAD_ENTRY) || evt_merge_events_enable);
    assign merge_hit = merge_ok && same_rec && (window != 16'h0000);
    assign issue = accept && (next_code != ierb_pkg::CODE_NONE) && !merge_hit;

    // One-record slot; the source stalls while the queue writer holds it off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_valid <= 1'b0;
            evt_ready <= 1'b0;
        end else if (issue) begin
            rec_valid <= 1'b1;
            evt_ready <= 1'b0;
        end else if (rec_valid && rec_ready) begin
            rec_valid <= 1'b0;
            evt_ready <= 1'b1;
        end else begin
            evt_ready <= !rec_valid;
        end
    end

    // Record and its queue selection; held after hand-off as the merge reference.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_data <= '0;
            rec_secure <= 1'b0;
        end else if (issue) begin
            rec_data <= packed_rec;
            rec_secure <= evt_secure;
        end
    end

    // Merge window: events further apart than this are written separately.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window <= 16'h0000;
        end else if (issue) begin
            window <= 16'(MERGE_CYC);
        end else if (window != 16'h0000) begin
            window <= window - 16'h0001;
        end
    end

    // Counters wrap silently; software reads them as a difference.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issued_count <= 16'h0000;
            merged_count <= 16'h0000;
        end else begin
            if (issue) begin
                issued_count <= issued_count + 16'h0001;
            end
            if (accept && (next_code != ierb_pkg::CODE_NONE) && merge_hit) begin
                merged_count <= merged_count + 16'h0001;
            end
        end
    end

    // Checks on the record path.
    sequence s_issue;
        evt_valid && evt_ready && (next_code != ierb_pkg::CODE_NONE) && !merge_hit;
    endsequence

    sequence s_uut;
        s_issue ##0 evt_unsupported;
    endsequence

    code_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        rec_valid |-> (rec_data[7:0] >= ierb_pkg::CODE_UUT)
            && (rec_data[7:0] <= ierb_pkg::CODE_BAD_ENTRY))
        else $error("record code outside the supported set");

    rec_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_secure))
        else $error("record changed while waiting");

    queue_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_issue |=> rec_valid && (rec_secure == $past(evt_secure)))
        else $error("record routed to the wrong queue");

    rnw_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_uut |=> rec_data[ierb_pkg::POS_RNW] == $past(evt_read_not_write))
        else $error("read_not_write mismatch");

    uut_attr_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_uut |=> (rec_data[ierb_pkg::POS_PRIV] == $past(evt_priv_in))
            && (rec_data[ierb_pkg::POS_INSTR] == $past(evt_instr_in)))
        else $error("unsupported event lost incoming attributes");

    addr_full_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_uut |=> rec_data[ierb_pkg::POS_IN_ADDR +: 64] == $past(evt_input_address))
        else $error("input address altered");

    ssv_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        rec_valid && !rec_data[ierb_pkg::POS_SSV]
            |-> rec_data[ierb_pkg::POS_SSID +: ierb_pkg::SSID_W] == 20'h00000)
        else $error("sub-stream identifier present without valid flag");

    nonsecure_ipa_flag_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        rec_valid && !(rec_secure && rec_data[ierb_pkg::POS_STAGE])
            |-> !rec_data[ierb_pkg::POS_NONSECURE_IPA_FLAG])
        else $error("nonsecure_ipa_flag set outside secure stage two");

    stall_nomerge_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept && evt_stall && (next_code != ierb_pkg::CODE_NONE) |=> rec_valid ##0 !evt_ready)
        else $error("stalled event merged");

    recinv_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_issue ##1 (rec_data[7:0] == ierb_pkg::CODE_BAD_SID)
            |-> $past(ctrl[ierb_pkg::CTRL_RECINV]))
        else $error("bad identifier recorded while disabled");

    fetch_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
        rec_valid && REV0 |-> rec_data[ierb_pkg::POS_FETCH + 48 +: 4] == 4'h0)
        else $error("fetch address bits 51:48 not zero");

    uut_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept && evt_unsupported && !merge_hit |=> rec_valid
            && (rec_data[7:0] == ierb_pkg::CODE_UUT))
        else $error("unsupported transaction not recorded");

    // The stage flag is copied straight from the request.
    stage_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_uut |=> rec_data[ierb_pkg::POS_STAGE] == $past(evt_fault_stage))
        else $error("fault_stage mismatch");

    // The reserved class code must never reach the queue.
    class_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_uut |=> rec_data[ierb_pkg::POS_CLASS +: 2] != 2'h3)
        else $error("reserved operation class written");

    // With merging switched off every real event must produce its own record.
    merge_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept && (next_code != ierb_pkg::CODE_NONE) && !ctrl[ierb_pkg::CTRL_MERGE]
            |=> rec_valid)
        else $error("event merged while merging is off");
endmodule

// *** test/ierb_client.sv ***
// Client bus master model that raises events and accepts finished records.
`timescale 1ns/1ps
module ierb_client (
    // Clock, reset and record pacing.
    input wire logic pclk, presetn, slow,
    // Event request toward the builder.
    output logic evt_valid, evt_unsupported, evt_secure, evt_substream_valid,
    output logic evt_read_not_write, evt_priv_in, evt_instr_in, evt_priv_ovr, evt_instr_ovr,
    output logic evt_fault_stage, evt_stage1_ns, evt_stall, evt_level1_fetched,
    output logic evt_fetch_abort, evt_entry_invalid, evt_merge_events_enable,
    output logic [15:0] evt_reason,
    output logic [31:0] evt_source_identifier,
    output logic [19:0] evt_sub_stream_identifier,
    output logic [63:0] evt_input_address, evt_fetch_address,
    output logic [1:0] evt_op_class,
    output logic [4:0] evt_level1_span,
    input wire logic evt_ready,
    // Record side.
    input wire logic rec_valid, rec_secure,
    input wire logic [255:0] rec_data,
    output logic rec_ready
);
    int nrec = 0;
    logic [255:0] last_rec = '0;
    logic last_sec = 1'b0;
    // Fixed attributes; the overridden ones differ so a wrong pick shows up.
    assign evt_reason = 16'h00a5;
    // The sub-stream flag follows the secure flag so both settings reach the record.
    assign evt_substream_valid = evt_secure;
    assign evt_sub_stream_identifier = 20'habcde;
    assign evt_read_not_write = 1'b1;
    assign evt_priv_in = 1'b1;
    assign evt_instr_in = 1'b0;
    assign evt_priv_ovr = 1'b0;
    assign evt_instr_ovr = 1'b1;
    assign evt_fault_stage = 1'b1;
    assign evt_stage1_ns = 1'b1;
    assign evt_op_class = 2'h2;
    assign evt_level1_span = 5'h00;
    assign evt_merge_events_enable = 1'b0;
    assign evt_fetch_address = {evt_input_address[31:0], evt_input_address[63:32]};
    // Idle request at time zero.
    initial begin
        evt_valid = 1'b0;
        {evt_level1_fetched, evt_secure, evt_unsupported} = 3'h0;
        {evt_fetch_abort, evt_entry_invalid, evt_stall} = 3'h0;
        evt_source_identifier = '0;
        evt_input_address = '0;
    end
    // A slow queue writer toggles ready so records must wait.
    always @(posedge pclk) begin
        rec_ready <= slow ? ~rec_ready : 1'b1;
    end
    // Records are taken at the rising edge where valid and ready are both high.
    always @(posedge pclk) begin
        if (rec_valid && rec_ready) begin
            nrec <= nrec + 1;
            last_rec <= rec_data;
            last_sec <= rec_secure;
        end
    end
    // One request, held until taken; released fields show inverted values.
    task automatic send(input logic [5:0] k, input logic [31:0] sid, input logic [63:0] a);
        evt_valid <= 1'b1;
        {evt_level1_fetched, evt_secure, evt_unsupported} <= k[5:3];
        {evt_fetch_abort, evt_entry_invalid, evt_stall} <= k[2:0];
        evt_source_identifier <= sid;
        evt_input_address <= a;
        do @(posedge pclk); while (evt_ready !== 1'b1);
        evt_valid <= 1'b0;
        evt_source_identifier <= ~sid;
        evt_input_address <= ~a;
        @(posedge pclk);
    endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the event record builder.
`timescale 1ns/1ps
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, e, evt_ready, rec_valid, rec_ready, rec_secure;
    logic [255:0] rec_data;
    logic evt_valid, evt_unsupported, evt_secure, evt_substream_valid;
    logic evt_read_not_write, evt_priv_in, evt_instr_in, evt_priv_ovr, evt_instr_ovr;
    logic evt_fault_stage, evt_stage1_ns, evt_stall, evt_level1_fetched;
    logic evt_fetch_abort, evt_entry_invalid, evt_merge_events_enable;
    logic [15:0] evt_reason;
    logic [31:0] evt_source_identifier;
    logic [19:0] evt_sub_stream_identifier;
    logic [63:0] evt_input_address, evt_fetch_address;
    logic [1:0] evt_op_class;
    logic [4:0] evt_level1_span;
    int mismatches = 0, checks = 0, cyc = 0;
    localparam logic [5:0] K_L1 = 6'h20, K_SEC = 6'h10, K_UUT = 6'h08;
    localparam logic [5:0] K_AB = 6'h04, K_INV = 6'h02, K_ST = 6'h01;
    localparam logic [63:0] ADDR_A = 64'hff00_1234_5678_9abc;
    // A short merge window keeps the merging cases quick.
    ierb_top #(.MERGE_CYC(4)) ierb_top_inst (.*);
    ierb_client ierb_client_inst (.*);
    // Clock at 40 MHz.
    always #12.5 pclk = ~pclk;
    // A hang counts as a mismatch and ends the run.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmprec(input logic [255:0] got, input logic [255:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t record %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer; the answer is taken at the rising edge that samples pready high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp32(r, exp);
    endtask
    // Expected record: only the fields each code defines, the rest zero.
    function automatic logic [255:0] mk(input logic [7:0] c, input logic [31:0] sid,
                                       input logic [63:0] a, input logic sec);
        logic [255:0] x;
        x = '0;
        x[7:0] = c;
        x[31:11] = sec ? {20'habcde, 1'b1} : 21'h000000;
        x[63:32] = sid;
        if (c == 8'h01 || c == 8'h03) x[79:64] = 16'h00a5;
        if (c == 8'h01) begin
            x[105:96] = {2'h2, 1'b1, 2'b00, sec, 1'b0, 3'b101};
            x[191:128] = a;
        end
        if (c == 8'h03) x[239:192] = {a[15:0], a[63:32]};
        return x;
    endfunction
    // Waits for the record to land, then checks count, content and queue.
    task automatic chk(input int n, input logic [7:0] c, input logic [31:0] sid,
                       input logic [63:0] a, input logic sec);
        repeat (6) @(posedge pclk);
        cmp32(32'(ierb_client_inst.nrec), 32'(n));
        cmprec(ierb_client_inst.last_rec, mk(c, sid, a, sec));
        cmp32({31'h0, ierb_client_inst.last_sec}, {31'h0, sec});
    endtask
    task automatic ev(input logic [5:0] k, input logic [31:0] sid);
        ierb_client_inst.send(k, sid, ADDR_A);
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h4);
        rd(12'h004, 32'h0);
        rd(12'h010, 32'h0);
        cmp32({31'h0, e}, 32'h1);
        // Translation off: an unsupported access records, its twin merges unless stalled.
        ev(K_UUT | K_SEC, 32'h7);
        ev(K_UUT | K_SEC, 32'h7);
        chk(1, 8'h01, 32'h7, ADDR_A, 1'b1);
        rd(12'h008, 32'h0001_0001);
        ev(K_UUT | K_ST, 32'h7);
        ev(K_UUT | K_ST, 32'h7);
        chk(3, 8'h01, 32'h7, ADDR_A, 1'b0);
        ev(K_AB, 32'h7);
        chk(3, 8'h01, 32'h7, ADDR_A, 1'b0);
        // Translation on, invalid-id recording on, sixteen entries.
        apb(1'b1, 12'h000, 32'h7);
        apb(1'b1, 12'h004, 32'h4);
        ev(6'h00, 32'h10);
        chk(4, 8'h02, 32'h10, ADDR_A, 1'b0);
        ev(K_AB | K_SEC, 32'hf);
        chk(5, 8'h03, 32'hf, ADDR_A, 1'b1);
        rd(12'h00c, 32'h0000_0103);
        ev(K_INV, 32'hf);
        ev(6'h00, 32'hf);
        chk(6, 8'h04, 32'hf, ADDR_A, 1'b0);
        // Merging off with a slow writer: identical events each get a record.
        apb(1'b1, 12'h000, 32'h3);
        slow <= 1'b1;
        ev(K_INV, 32'hf);
        ev(K_INV, 32'hf);
        chk(8, 8'h04, 32'hf, ADDR_A, 1'b0);
        slow <= 1'b0;
        apb(1'b1, 12'h000, 32'h7);
        ev(K_INV, 32'hf);
        ev(K_INV, 32'he);
        chk(10, 8'h04, 32'he, ADDR_A, 1'b0);
        apb(1'b1, 12'h000, 32'h5);
        ev(6'h00, 32'h10);
        chk(10, 8'h04, 32'he, ADDR_A, 1'b0);
        // Two-level table: a level-one span of zero is a bad identifier.
        apb(1'b1, 12'h000, 32'hb);
        apb(1'b1, 12'h004, 32'h0408);
        ev(K_L1, 32'h3);
        chk(11, 8'h02, 32'h3, ADDR_A, 1'b0);
        give_verdict();
    end
endmodule
